// [hw/spss_consts.vh]
/*
 * Constants for the stepper phase and start-sync block: register offsets,
 * field positions, command codes, status codes and delay times.
 * Assumes a 20 MHz clock; times are kept in their own unit and turned
 * into cycle counts by the macros at the end.
 */
`ifndef SPSS_CONSTS_VH
`define SPSS_CONSTS_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each).
// ----------------------------------------------------------------------
`define SPSS_A_CMD 8'h00
`define SPSS_A_MODE 8'h04
`define SPSS_A_ENV1 8'h08
`define SPSS_A_ENV2 8'h0c
`define SPSS_A_STAT 8'h10
`define SPSS_A_CAUSE 8'h14
// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define SPSS_B_SEL 23
`define SPSS_B_POST 20
`define SPSS_B_POL 19
`define SPSS_B_PRE 16
`define SPSS_B_TRIG 13
`define SPSS_B_END_MODE_SELECT 5
`define SPSS_B_SYNC 12
`define SPSS_B_FILT 15
`define SPSS_B_IEN 19
`define SPSS_B_ICAUSE 9
`define SPSS_B_STAON 29
`define SPSS_B_OPST 24
`define SPSS_B_PH 4
`define SPSS_RST_REG 32'h0000_0000
// ----------------------------------------------------------------------
// Commands and operation status codes.
// ----------------------------------------------------------------------
`define SPSS_CMD_START 8'h01
`define SPSS_CMD_SIMSTA 8'h12
`define SPSS_CMD_STOP 8'h32
`define SPSS_ST_IDLE 4'h0
`define SPSS_ST_PRE 4'h1
`define SPSS_ST_RUN 4'h2
`define SPSS_ST_POST 4'h3
`define SPSS_ST_PULSE 4'h4
`define SPSS_ST_LOAD 4'h5
`define SPSS_ST_WAIT 4'hc
// ----------------------------------------------------------------------
// Times and their cycle counts.
// ----------------------------------------------------------------------
`define SPSS_CLK_MHZ 20
`define SPSS_PRE0_US 12
`define SPSS_PRE1_US 102
`define SPSS_PRE2_US 409
`define SPSS_PRE3_US 1600
`define SPSS_PRE4_US 13000
`define SPSS_PRE5_US 52000
`define SPSS_PRE6_US 104000
`define SPSS_POST1_US 12
`define SPSS_POST2_US 1600
`define SPSS_POST3_US 52000
`define SPSS_POST4_US 104000
`define SPSS_POST5_US 208000
`define SPSS_POST6_US 416000
`define SPSS_POST7_US 832000
// Start filter lengths count plain clocks, so the eight-cycle one-shot of
// a neighbouring axis always passes the short filter.
`define SPSS_FSHORT_CYC 5
`define SPSS_FLONG_CYC 393218
`define SPSS_ONESHOT_CYC 8
`define SPSS_US2CYC(t) ((t) * `SPSS_CLK_MHZ)
`endif

// [hw/spss_phase_seq.v]
/*
 * Four-output excitation sequencer for a two-phase stepper motor.
 * Assumes step and dir come from logic on the same clock and that
 * half and bipolar are already synchronised.
 */
`timescale 1ns/10ps
module spss_phase_seq
(
	input wire clk,
	input wire rst,
	input wire step,
	input wire dir,
	input wire half,
	input wire bipolar,
	output reg [3:0] ph_q
);
	reg [2:0] idx_q;
	reg [2:0] idx_d;
	reg [3:0] ph_d;

	// ------------------------------------------------------------------
	// Step index: plus advances, minus retreats, wraps at 4 or 8.
	// ------------------------------------------------------------------
	always @*
	begin
		idx_d = idx_q;
		if (step)
		begin
			if (dir)
				idx_d = idx_q + 3'h1;
			else
				idx_d = idx_q - 3'h1;
		end
		if (!half)
			idx_d[2] = 1'b0; // Full step uses four positions.
	end

	// Pattern lookup; bit 3 is phase one, bit 0 is phase four.
	always @*
	begin
		case ({bipolar, half, idx_d})
			5'h00: ph_d = 4'h9;
			5'h01: ph_d = 4'hc;
			5'h02: ph_d = 4'h6;
			5'h03: ph_d = 4'h3;
			5'h08: ph_d = 4'h9;
			5'h09: ph_d = 4'h8;
			5'h0a: ph_d = 4'hc;
			5'h0b: ph_d = 4'h4;
			5'h0c: ph_d = 4'h6;
			5'h0d: ph_d = 4'h2;
			5'h0e: ph_d = 4'h3;
			5'h0f: ph_d = 4'h1;
			5'h10: ph_d = 4'h8;
			5'h11: ph_d = 4'hc;
			5'h12: ph_d = 4'h4;
			5'h13: ph_d = 4'h0;
			5'h18: ph_d = 4'h8;
			5'h19: ph_d = 4'h9;
			5'h1a: ph_d = 4'hc;
			5'h1b: ph_d = 4'he;
			5'h1c: ph_d = 4'h4;
			5'h1d: ph_d = 4'h5;
			5'h1e: ph_d = 4'h0;
			5'h1f: ph_d = 4'h2;
			default: ph_d = 4'h0;
		endcase
	end

	// The outputs follow the pins one clock later, so a mode change shows live.
	always @(posedge clk)
	begin
		if (rst)
		begin
			idx_q <= 3'h0;
			ph_q <= 4'h9;
		end
		else
		begin
			idx_q <= idx_d;
			ph_q <= ph_d;
		end
	end
endmodule // spss_phase_seq

// [hw/spss_top.v]
/*
 * Current reduction, excitation outputs and synchronised start for one
 * pulse-control axis, with a plain register port.
 * Assumes a pulse engine on the same clock supplies steps and the end of
 * an operation, and a pattern loader answers load requests.
 */
// Summary of operation
// - Select bit routes reduction onto shared terminal
// - Pre-start delay after reduction release
// - Post-operation delay before reduction asserts
// - Pulses step phases forward or back
// - Half/full pin picks four or eight steps
// - Drive-type pin picks unipolar or bipolar
// - Unipolar pattern tables
// - Phase levels readable in status
// - Sync mode waits for start line low
// - Start in sync mode shows wait code
// - Simultaneous start drives line eight cycles
// - Immediate stop releases start wait
// - Level or edge start detection
// - Start filter ignores short pulses
// - Start-on raises interrupt cause bit
// - Status shows start line state
// - Select pins pick one of 32 patterns
// - Pin change loads and starts pattern
// - Pin change mid-operation stops first
// - Pulse-input patterns wait for pulse inputs
`timescale 1ns/10ps
`include "spss_consts.vh"
module spss_top
#(
	parameter [23:0] PRE_C2 = `SPSS_US2CYC(`SPSS_PRE2_US),
	parameter [23:0] PRE_C3 = `SPSS_US2CYC(`SPSS_PRE3_US),
	parameter [23:0] PRE_C4 = `SPSS_US2CYC(`SPSS_PRE4_US),
	parameter [23:0] PRE_C5 = `SPSS_US2CYC(`SPSS_PRE5_US),
	parameter [23:0] PRE_C6 = `SPSS_US2CYC(`SPSS_PRE6_US),
	parameter [23:0] POST_C2 = `SPSS_US2CYC(`SPSS_POST2_US),
	parameter [23:0] POST_C3 = `SPSS_US2CYC(`SPSS_POST3_US),
	parameter [23:0] POST_C4 = `SPSS_US2CYC(`SPSS_POST4_US),
	parameter [23:0] POST_C5 = `SPSS_US2CYC(`SPSS_POST5_US),
	parameter [23:0] POST_C6 = `SPSS_US2CYC(`SPSS_POST6_US),
	parameter [23:0] POST_C7 = `SPSS_US2CYC(`SPSS_POST7_US),
	parameter [19:0] FLT_LONG = `SPSS_FLONG_CYC
)
(
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire start_line_i,
	output reg start_line_o,
	output reg start_line_oe,
	input wire half_full_step_select_pin,
	input wire drive_type_select_pin,
	input wire standalone_pin,
	input wire [4:0] pattern_select_pins,
	input wire pulse_a_or_plus_dir_input,
	input wire pulse_b_or_minus_dir_input,
	input wire step_pulse,
	input wire step_dir,
	input wire op_done,
	input wire servo_clear,
	input wire load_done,
	input wire load_sync,
	input wire load_pulse_wait,
	output reg clear_or_reduction_terminal,
	output reg phase_output_1,
	output reg phase_output_2,
	output reg phase_output_3,
	output reg phase_output_4,
	output reg pulse_enable,
	output reg stop_req,
	output reg load_req,
	output reg [4:0] load_index,
	output reg start_interrupt_cause
);
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_WAIT = 3'h1;
	localparam [2:0] S_PRE = 3'h2;
	localparam [2:0] S_PULSE = 3'h3;
	localparam [2:0] S_RUN = 3'h4;
	localparam [2:0] S_POST = 3'h5;
	localparam [2:0] S_LOAD = 3'h6;
	localparam [23:0] PRE_C0 = `SPSS_US2CYC(`SPSS_PRE0_US);
	localparam [23:0] PRE_C1 = `SPSS_US2CYC(`SPSS_PRE1_US);
	localparam [23:0] POST_C1 = `SPSS_US2CYC(`SPSS_POST1_US);
	localparam [19:0] FLT_SHORT = `SPSS_FSHORT_CYC;
	localparam [3:0] SHOT = `SPSS_ONESHOT_CYC;

	// Register file and control state.
	reg [31:0] mode_q;
	reg [31:0] env1_q;
	reg [31:0] env2_q;
	reg [2:0] st_q;
	reg [23:0] cnt_q;
	reg red_q;
	reg pwait_q;
	reg [3:0] shot_q;
	// Synchronisers; the first stage is read only by the second.
	reg [1:0] sta_s;
	reg [1:0] hf_s;
	reg [1:0] ub_s;
	reg [1:0] sa_s;
	reg [1:0] pa_s;
	reg [1:0] pb_s;
	reg [4:0] ps1_q;
	reg [4:0] ps2_q;
	reg [4:0] ps_last_q;
	reg ps_init_q;
	reg pa3_q;
	reg pb3_q;
	reg sta_on_q;
	reg [19:0] flt_q;
	wire [3:0] ph;
	wire wr_cmd;
	wire cmd_start;
	wire cmd_sim;
	wire cmd_stop;
	wire sta_rise;
	wire trig;
	wire ps_change;
	wire pulse_seen;
	wire [19:0] flt_thr;
	reg [23:0] pre_cnt;
	reg [23:0] post_cnt;
	reg [3:0] opst;

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	assign wr_cmd = wr && (addr == `SPSS_A_CMD);
	assign cmd_start = wr_cmd && (wdata[7:0] == `SPSS_CMD_START);
	assign cmd_sim = wr_cmd && (wdata[7:0] == `SPSS_CMD_SIMSTA);
	assign cmd_stop = wr_cmd && (wdata[7:0] == `SPSS_CMD_STOP);

	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	always @(posedge clk)
	begin
		if (rst)
		begin
			sta_s <= 2'b11;
			hf_s <= 2'b00;
			ub_s <= 2'b00;
			sa_s <= 2'b00;
			pa_s <= 2'b11;
			pb_s <= 2'b11;
			ps1_q <= 5'h00;
			ps2_q <= 5'h00;
			pa3_q <= 1'b1;
			pb3_q <= 1'b1;
		end
		else
		begin
			sta_s <= {sta_s[0], start_line_i};
			hf_s <= {hf_s[0], half_full_step_select_pin};
			ub_s <= {ub_s[0], drive_type_select_pin};
			sa_s <= {sa_s[0], standalone_pin};
			pa_s <= {pa_s[0], pulse_a_or_plus_dir_input};
			pb_s <= {pb_s[0], pulse_b_or_minus_dir_input};
			ps1_q <= pattern_select_pins;
			ps2_q <= ps1_q;
			pa3_q <= pa_s[1];
			pb3_q <= pb_s[1];
		end
	end

	// ------------------------------------------------------------------
	// Start line filter
	// ------------------------------------------------------------------
	// The filtered state changes only after the raw line has held the
	// other level for the threshold; glitches simply restart the count.
	assign flt_thr = env2_q[`SPSS_B_FILT] ? FLT_LONG : FLT_SHORT;
	assign sta_rise = !sta_s[1] && !sta_on_q && (flt_q >= flt_thr - 20'h1);

	always @(posedge clk)
	begin
		if (rst)
		begin
			sta_on_q <= 1'b0;
			flt_q <= 20'h0;
		end
		else if ((!sta_s[1]) == sta_on_q)
			flt_q <= 20'h0;
		else if (flt_q >= flt_thr - 20'h1)
		begin
			sta_on_q <= !sta_s[1];
			flt_q <= 20'h0;
		end
		else
			flt_q <= flt_q + 20'h1;
	end

	// Our own one-shot triggers this axis directly, a few cycles before
	// the line would through the short filter, since the filter only counts clocks.
	assign trig = (env1_q[`SPSS_B_TRIG] ? sta_rise : sta_on_q) || cmd_sim;

	// ------------------------------------------------------------------
	// Pattern select and pulse input watch
	// ------------------------------------------------------------------
	assign ps_change = sa_s[1] && ps_init_q && (ps2_q != ps_last_q);
	assign pulse_seen = (pa3_q && !pa_s[1]) || (pb3_q && !pb_s[1]);

	// ------------------------------------------------------------------
	// Delay lookup
	// ------------------------------------------------------------------
	always @*
	begin
		case (env1_q[`SPSS_B_PRE+2:`SPSS_B_PRE])
			3'h0: pre_cnt = PRE_C0;
			3'h1: pre_cnt = PRE_C1;
			3'h2: pre_cnt = PRE_C2;
			3'h3: pre_cnt = PRE_C3;
			3'h4: pre_cnt = PRE_C4;
			3'h5: pre_cnt = PRE_C5;
			3'h6: pre_cnt = PRE_C6;
			default: pre_cnt = 24'h0; // Level output: no timed gap.
		endcase
		case (env1_q[`SPSS_B_POST+2:`SPSS_B_POST])
			3'h0: post_cnt = 24'h0;
			3'h1: post_cnt = POST_C1;
			3'h2: post_cnt = POST_C2;
			3'h3: post_cnt = POST_C3;
			3'h4: post_cnt = POST_C4;
			3'h5: post_cnt = POST_C5;
			3'h6: post_cnt = POST_C6;
			default: post_cnt = POST_C7;
		endcase
	end

	// ------------------------------------------------------------------
	// Operation sequencer
	// ------------------------------------------------------------------
	// A start during post delay or loading is ignored; immediate stop
	// ends the start wait at once, and ends pre delay, pulse wait or run through the post delay.
	always @(posedge clk)
	begin
		if (rst)
		begin
			st_q <= S_IDLE;
			cnt_q <= 24'h0;
			red_q <= 1'b0;
			pwait_q <= 1'b0;
			pulse_enable <= 1'b0;
			stop_req <= 1'b0;
			load_req <= 1'b0;
			load_index <= 5'h00;
			ps_last_q <= 5'h00;
			ps_init_q <= 1'b0;
		end
		else
		begin
			stop_req <= 1'b0;
			load_req <= 1'b0;
			ps_init_q <= sa_s[1]; // Arms late, so power-up pins load nothing.
			if (!ps_init_q)
				ps_last_q <= ps2_q;
			if (ps_change)
			begin
				// Stop whatever runs and fetch the new pattern in the same cycle.
				ps_last_q <= ps2_q;
				stop_req <= (st_q != S_IDLE) && (st_q != S_LOAD);
				pulse_enable <= 1'b0;
				load_req <= 1'b1;
				load_index <= ps2_q;
				st_q <= S_LOAD;
			end
			else
			begin
				case (st_q)
					S_IDLE:
					begin
						if (cmd_start)
						begin
							pwait_q <= 1'b0;
							if (mode_q[`SPSS_B_SYNC])
								st_q <= S_WAIT;
							else
							begin
								red_q <= 1'b0;
								cnt_q <= pre_cnt;
								st_q <= S_PRE;
							end
						end
					end
					S_LOAD:
					begin
						if (load_done)
						begin
							pwait_q <= load_pulse_wait;
							if (load_sync)
								st_q <= S_WAIT;
							else
							begin
								red_q <= 1'b0;
								cnt_q <= pre_cnt;
								st_q <= S_PRE;
							end
						end
					end
					S_WAIT:
					begin
						if (cmd_stop)
							st_q <= S_IDLE;
						else if (trig)
						begin
							red_q <= 1'b0;
							cnt_q <= pre_cnt;
							st_q <= S_PRE;
						end
					end
					S_PRE:
					begin
						if (cmd_stop)
						begin
							cnt_q <= post_cnt;
							st_q <= S_POST;
						end
						else if (cnt_q == 24'h0)
						begin
							if (pwait_q)
								st_q <= S_PULSE;
							else
							begin
								pulse_enable <= 1'b1;
								st_q <= S_RUN;
							end
						end
						else
							cnt_q <= cnt_q - 24'h1;
					end
					S_PULSE:
					begin
						if (cmd_stop)
						begin
							cnt_q <= post_cnt;
							st_q <= S_POST;
						end
						else if (pulse_seen)
						begin
							pulse_enable <= 1'b1;
							st_q <= S_RUN;
						end
					end
					S_RUN:
					begin
						if (op_done || cmd_stop)
						begin
							stop_req <= cmd_stop;
							pulse_enable <= 1'b0;
							cnt_q <= post_cnt;
							st_q <= S_POST;
						end
					end
					S_POST:
					begin
						if (cnt_q == 24'h0)
						begin
							red_q <= 1'b1;
							st_q <= S_IDLE;
						end
						else
							cnt_q <= cnt_q - 24'h1;
					end
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers, one-shot, outputs
	// ------------------------------------------------------------------
	// The cause bit is cleared by writing a one; a new start event in the
	// same cycle wins so it is never lost.
	always @(posedge clk)
	begin
		if (rst)
		begin
			mode_q <= `SPSS_RST_REG;
			env1_q <= `SPSS_RST_REG;
			env2_q <= `SPSS_RST_REG;
			shot_q <= 4'h0;
			start_line_o <= 1'b0;
			start_line_oe <= 1'b0;
			start_interrupt_cause <= 1'b0;
		end
		else
		begin
			start_line_o <= 1'b0;
			if (wr && addr == `SPSS_A_MODE)
				mode_q <= wdata;
			if (wr && addr == `SPSS_A_ENV1)
				env1_q <= wdata;
			if (wr && addr == `SPSS_A_ENV2)
				env2_q <= wdata;
			if (cmd_sim)
				shot_q <= SHOT;
			else if (shot_q != 4'h0)
				shot_q <= shot_q - 4'h1;
			start_line_oe <= cmd_sim || (shot_q > 4'h1);
			if (sta_rise && env2_q[`SPSS_B_IEN])
				start_interrupt_cause <= 1'b1;
			else if (wr && addr == `SPSS_A_CAUSE && wdata[`SPSS_B_ICAUSE])
				start_interrupt_cause <= 1'b0;
		end
	end

	// Operation status code for the status register.
	always @*
	begin
		case (st_q)
			S_WAIT: opst = `SPSS_ST_WAIT;
			S_PRE: opst = `SPSS_ST_PRE;
			S_PULSE: opst = `SPSS_ST_PULSE;
			S_RUN: opst = `SPSS_ST_RUN;
			S_POST: opst = `SPSS_ST_POST;
			S_LOAD: opst = `SPSS_ST_LOAD;
			default: opst = `SPSS_ST_IDLE;
		endcase
	end

	// Read data stand one cycle after the strobe; unmapped reads zero.
	always @(posedge clk)
	begin
		if (rst)
			rdata <= 32'h0;
		else if (rd)
		begin
			case (addr)
				`SPSS_A_MODE: rdata <= mode_q;
				`SPSS_A_ENV1: rdata <= env1_q;
				`SPSS_A_ENV2: rdata <= env2_q;
				`SPSS_A_STAT: rdata <= ({31'h0, sta_on_q} << `SPSS_B_STAON) |
					({28'h0, opst} << `SPSS_B_OPST) |
					({28'h0, ph} << `SPSS_B_PH);
				`SPSS_A_CAUSE: rdata <= {31'h0, start_interrupt_cause} << `SPSS_B_ICAUSE;
				default: rdata <= 32'h0;
			endcase
		end
		else
			rdata <= 32'h0;
	end

	// Terminal mux and phase outputs, all registered.
	always @(posedge clk)
	begin
		if (rst)
		begin
			clear_or_reduction_terminal <= 1'b0;
			phase_output_1 <= 1'b1;
			phase_output_2 <= 1'b0;
			phase_output_3 <= 1'b0;
			phase_output_4 <= 1'b1;
		end
		else
		begin
			if (env1_q[`SPSS_B_SEL])
				clear_or_reduction_terminal <= env1_q[`SPSS_B_POL] ? red_q : !red_q;
			else
				clear_or_reduction_terminal <= servo_clear;
			phase_output_1 <= ph[3];
			phase_output_2 <= ph[2];
			phase_output_3 <= ph[1];
			phase_output_4 <= ph[0];
		end
	end

	// Steps only count while pulse output is enabled.
	spss_phase_seq u_seq
	(
		.clk(clk),
		.rst(rst),
		.step(step_pulse && pulse_enable),
		.dir(step_dir),
		.half(hf_s[1]),
		.bipolar(ub_s[1]),
		.ph_q(ph)
	);
endmodule // spss_top

// [tb/spss_props_properties.sv]
/* Port checker for spss_top.
   Assumes it is bound to spss_top and shares its clk and rst. */
`timescale 1ns/10ps
`include "spss_consts.vh"
module spss_props
(
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	input wire start_line_o,
	input wire start_line_oe,
	input wire step_pulse,
	input wire op_done,
	input wire clear_or_reduction_terminal,
	input wire phase_output_1,
	input wire phase_output_2,
	input wire phase_output_3,
	input wire phase_output_4,
	input wire pulse_enable,
	input wire load_req,
	input wire start_interrupt_cause
);
// ----------------------------------------------------------------------
// Helpers.
// ----------------------------------------------------------------------
reg [31:0] env1_q;
wire [3:0] ph = {phase_output_1, phase_output_2, phase_output_3, phase_output_4};
wire term = clear_or_reduction_terminal;
wire cmd12 = wr && addr == `SPSS_A_CMD && wdata[7:0] == `SPSS_CMD_SIMSTA;
wire cclr = wr && addr == `SPSS_A_CAUSE && wdata[9];
// Shadow of the environment word, so polarity is known without a read.
always @(posedge clk)
	if (rst)
		env1_q <= 32'h0;
	else if (wr && addr == `SPSS_A_ENV1)
		env1_q <= wdata;
default clocking cb @(posedge clk);
endclocking
default disable iff (rst);
// ----------------------------------------------------------------------
// Properties.
// ----------------------------------------------------------------------
property p_oe_len;
	$rose(start_line_oe) |-> start_line_oe[*8] ##1 !start_line_oe;
endproperty
a_oe_len: assert property (p_oe_len) else $error("start drive not 8 cycles");
property p_oe_cause;
	$rose(start_line_oe) |-> $past(cmd12);
endproperty
a_oe_cause: assert property (p_oe_cause) else $error("start drive unprompted");
property p_od;
	start_line_oe |-> !start_line_o;
endproperty
a_od: assert property (p_od) else $error("start line driven high");
// Steps are spaced apart, so three edges later the pattern must differ.
property p_step;
	step_pulse && pulse_enable |-> ##3 ph != $past(ph, 3);
endproperty
a_step: assert property (p_step) else $error("step did not move phases");
property p_run_lvl;
	env1_q[23] && pulse_enable && $past(pulse_enable) && $stable(env1_q)
		|-> term == !env1_q[19];
endproperty
a_run_lvl: assert property (p_run_lvl) else $error("terminal wrong in run");
property p_done;
	op_done && pulse_enable |=> !pulse_enable;
endproperty
a_done: assert property (p_done) else $error("pulses not stopped");
property p_post0;
	op_done && pulse_enable && env1_q[23] && env1_q[22:20] == 3'h0
		|-> ##3 term == env1_q[19];
endproperty
a_post0: assert property (p_post0) else $error("reduction late");
property p_load;
	load_req |-> !pulse_enable ##1 !load_req;
endproperty
a_load: assert property (p_load) else $error("load request wrong");
property p_cause;
	start_interrupt_cause && !cclr |=> start_interrupt_cause;
endproperty
a_cause: assert property (p_cause) else $error("cause bit lost");
property p_rd0;
	!rd |=> rdata == 32'h0;
endproperty
a_rd0: assert property (p_rd0) else $error("read data without read");
endmodule // spss_props
bind spss_top spss_props spss_props_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .start_line_o(start_line_o),
	.start_line_oe(start_line_oe), .step_pulse(step_pulse), .op_done(op_done),
	.clear_or_reduction_terminal(clear_or_reduction_terminal),
	.phase_output_1(phase_output_1), .phase_output_2(phase_output_2),
	.phase_output_3(phase_output_3), .phase_output_4(phase_output_4),
	.pulse_enable(pulse_enable), .load_req(load_req),
	.start_interrupt_cause(start_interrupt_cause));

// [tb/spss_peer.sv]
/* Model of another axis on the shared open-drain start line.
   Assumes the bench resolves the wire with a pull-up. */
`timescale 1ns/10ps
module spss_peer
(
	input wire clk,
	input wire go,
	input wire [15:0] len,
	input wire till_done,
	input wire done,
	output reg pull = 1'b0
);
integer n = 0;
// Pulls the line low for len cycles, or until done in end mode.
always @(posedge clk)
	if (go)
	begin
		pull <= 1'b1;
		n <= len;
	end
	else if (n > 1)
		n <= n - 1;
	else if (!till_done || done)
	begin
		pull <= 1'b0;
		n <= 0;
	end
endmodule // spss_peer

// [tb/spss_top_tb.sv]
/* Self-checking bench for spss_top.
   Assumes the consts header and short delay parameters set below. */
`timescale 1ns/10ps
`include "spss_consts.vh"
module spss_top_tb;
reg clk = 0, rst = 1, wr = 0, rd = 0, half = 0, bip = 0, sa = 0, step = 0, sdir = 0;
reg done = 0, sclr = 0, ldone = 0, lsync = 0, lpw = 0, pa = 1, pb = 1, pgo = 0, till = 0;
reg [7:0] addr = 0;
reg [31:0] wdata = 0, d, seed = 32'h0860;
reg [4:0] ps = 0, e;
reg [15:0] plen = 0;
wire [31:0] rdata;
wire oe, so, pull, term, p1, p2, p3, p4, pe, sreq, lreq, icause;
wire [4:0] lidx;
wire shared_start_line = !((oe && !so) || pull); // Open drain with pull-up.
int bad_count = 0, n_checks = 0, i, k, idx, n, pol, th;
int prec[4] = '{0, 1, 2, 7}, pren[4] = '{240, 2040, 20, 0};
int postc[4] = '{2, 0, 7, 1}, postn[4] = '{20, 0, 30, 240};
always #25 clk = ~clk;
spss_top #(.PRE_C2(20), .POST_C2(20), .POST_C7(30), .FLT_LONG(30)) spss_top_i (
	.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.start_line_i(shared_start_line), .start_line_o(so), .start_line_oe(oe),
	.half_full_step_select_pin(half), .drive_type_select_pin(bip), .standalone_pin(sa),
	.pattern_select_pins(ps), .pulse_a_or_plus_dir_input(pa),
	.pulse_b_or_minus_dir_input(pb), .step_pulse(step), .step_dir(sdir), .op_done(done),
	.servo_clear(sclr), .load_done(ldone), .load_sync(lsync), .load_pulse_wait(lpw),
	.clear_or_reduction_terminal(term), .phase_output_1(p1), .phase_output_2(p2),
	.phase_output_3(p3), .phase_output_4(p4), .pulse_enable(pe), .stop_req(sreq),
	.load_req(lreq), .load_index(lidx), .start_interrupt_cause(icause));
spss_peer spss_peer_i (.clk(clk), .go(pgo), .len(plen), .till_done(till), .done(done),
	.pull(pull));
// ----------------------------------------------------------------------
// Model and bus tasks.
// ----------------------------------------------------------------------
function [31:0] xs(input [31:0] x);
	x ^= x << 13;
	x ^= x >> 17;
	x ^= x << 5;
	xs = x;
endfunction
// Phase tables packed step 0 first, phase 1 in the top bit.
function automatic [3:0] ph_exp(input logic h, b, input int i);
	reg [31:0] t;
	t = b ? (h ? 32'h89ce4502 : 32'h8c40) : (h ? 32'h98c46231 : 32'h9c63);
	ph_exp = t >> (4 * ((h ? 7 : 3) - i));
endfunction
task tally_and_finish;
	$display("checks %0d mismatches %0d", n_checks, bad_count);
	if (bad_count == 0 && n_checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
task chk(input [31:0] s, x);
	n_checks++;
	if (s !== x)
	begin
		bad_count++;
		$display("Error t=%0t seen=%h exp=%h", $time, s, x);
	end
endtask
task tick(input int c);
	repeat (c) @(posedge clk);
	#1;
endtask
task wreg(input [7:0] a, input [31:0] v);
	@(posedge clk);
	addr <= a;
	wdata <= v;
	wr <= 1;
	@(posedge clk);
	wr <= 0;
endtask
task rreg(input [7:0] a);
	@(posedge clk);
	addr <= a;
	rd <= 1;
	@(posedge clk);
	rd <= 0;
	#1 d = rdata;
endtask
task code(input [3:0] x);
	rreg(`SPSS_A_STAT);
	chk(d[27:24], x);
endtask
// Bounded wait on pulse enable (sel 0) or load request (sel 1).
task wait_hi(input logic sel, input int lim, output int c);
	c = 0;
	#1;
	while (!(sel ? lreq : pe) && c < lim)
	begin
		tick(1);
		c++;
	end
	if (c >= lim)
	begin
		bad_count++;
		tally_and_finish;
	end
endtask
task do_rst;
	@(posedge clk);
	rst <= 1;
	repeat (5) @(posedge clk);
	rst <= 0;
endtask
task opdone;
	@(posedge clk);
	done <= 1;
	@(posedge clk);
	done <= 0;
endtask
task kick(input [15:0] l);
	@(posedge clk);
	pgo <= 1;
	plen <= l;
	@(posedge clk);
	pgo <= 0;
endtask
task sa_load(input logic act, s, w);
	seed = xs(seed);
	e = ps ^ (seed[4:0] | 5'h1);
	@(posedge clk);
	ps <= e;
	wait_hi(1, 20, k);
	chk(lidx, e);
	chk(sreq, act);
	@(posedge clk);
	ldone <= 1;
	lsync <= s;
	lpw <= w;
	@(posedge clk);
	ldone <= 0;
	tick(2);
endtask
// ----------------------------------------------------------------------
// Main sequence.
// ----------------------------------------------------------------------
initial
begin
	do_rst;
	tick(1);
	chk({p1, p2, p3, p4, term, oe, pe, sreq, lreq, icause}, 10'h240);
	sclr <= 1;
	tick(2);
	chk(term, 1'b1);
	rreg(`SPSS_A_ENV1);
	chk(d, 32'h0);
	wreg(8'h3c, 32'hffff_ffff);
	rreg(8'h3c);
	chk(d, 32'h0);
	$display("reset test done");
	for (i = 0; i < 4; i++)
	begin
		pol = i & 1;
		wreg(`SPSS_A_ENV1, 32'h80_0000 | pol << 19 | postc[i] << 20 | prec[i] << 16);
		wreg(`SPSS_A_CMD, 32'h1);
		wait_hi(0, 3000, k);
		chk(k, pren[i] + 1);
		chk(term, !pol);
		opdone;
		tick(postn[i] + 1);
		chk(term, !pol);
		tick(1);
		chk(term, pol);
	end
	$display("reduction test done");
	for (i = 0; i < 4; i++)
	begin
		half <= i[0];
		bip <= i[1];
		do_rst;
		wreg(`SPSS_A_ENV1, 32'h7 << 16);
		wreg(`SPSS_A_CMD, 32'h1);
		wait_hi(0, 10, k);
		idx = 0;
		n = half ? 8 : 4;
		repeat (12)
		begin
			seed = xs(seed);
			@(posedge clk);
			step <= 1;
			sdir <= seed[0];
			@(posedge clk);
			step <= 0;
			idx = (idx + (seed[0] ? 1 : n - 1)) % n;
			tick(2);
			chk({p1, p2, p3, p4}, ph_exp(half, bip, idx));
		end
		rreg(`SPSS_A_STAT);
		chk(d[7:4], ph_exp(half, bip, idx));
	end
	$display("phase test done");
	do_rst;
	wreg(`SPSS_A_MODE, 32'h1 << 12);
	wreg(`SPSS_A_CMD, 32'h1);
	code(4'hc);
	tick(20);
	code(4'hc);
	wreg(`SPSS_A_CMD, 32'h12);
	tick(2);
	code(4'h1);
	wreg(`SPSS_A_CMD, 32'h32);
	tick(12);
	wreg(`SPSS_A_CMD, 32'h1);
	wreg(`SPSS_A_CMD, 32'h32);
	tick(2);
	code(4'h0);
	$display("sync test done");
	for (i = 0; i < 2; i++)
	begin
		th = i ? 30 : 5;
		wreg(`SPSS_A_ENV2, i << 15 | 32'h1 << 19);
		wreg(`SPSS_A_CMD, 32'h1);
		kick(th - 2);
		tick(th + 10);
		code(4'hc);
		chk({d[29], icause}, 2'b00);
		kick(th + 15);
		tick(th + 8);
		code(4'h1);
		chk({d[29], icause}, 2'b11);
		rreg(`SPSS_A_CAUSE);
		chk(d[9], 1'b1);
		wreg(`SPSS_A_CAUSE, 32'h1 << 9);
		tick(1);
		chk(icause, 1'b0);
		tick(th + 20);
		rreg(`SPSS_A_STAT);
		chk(d[29], 1'b0);
		wreg(`SPSS_A_CMD, 32'h32);
		tick(3);
	end
	for (i = 0; i < 2; i++)
	begin
		wreg(`SPSS_A_ENV1, i << 13);
		kick(80);
		tick(40);
		wreg(`SPSS_A_CMD, 32'h1);
		tick(1);
		code(i ? 4'hc : 4'h1);
		wreg(`SPSS_A_CMD, 32'h32);
		tick(60);
	end
	$display("start line test done");
	sa <= 1;
	ps <= 5'h15;
	do_rst;
	tick(4);
	code(4'h0);
	sa_load(0, 0, 0);
	code(4'h1);
	sa_load(1, 0, 1);
	tick(245);
	code(4'h4);
	@(posedge clk);
	pa <= 0;
	tick(6);
	code(4'h2);
	sa_load(1, 1, 0);
	code(4'hc);
	till <= 1;
	kick(20);
	tick(260);
	code(4'h2);
	opdone;
	tick(1);
	chk(shared_start_line, 1'b1);
	$display("stand-alone test done");
	tally_and_finish;
end
endmodule // spss_top_tb
